// [cfs_top.sv]
// Purpose: feedback status and error flags of a single counter channel
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   counting core and comparator switching live outside
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cfs_top
  import cfs_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [7:0]          haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output var  logic [31:0]         hrdata,
  output var  logic                hreadyout,
  output var  logic                hresp,
  // field detectors and counting core
  input  wire cfs_pkg::cfs_fault_t fault_in,
  input  wire cfs_pkg::cfs_core_t  core_in,
  // to the core
  output var  logic [4:0]          load_cmd,
  output var  logic                load_reject,
  // interrupt
  output var  logic                irq
);
  import cfs_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [31:0] irq_st;
  logic [31:0] next_irq_st;
  logic [31:0] irq_mask;
  logic [31:0] next_irq_mask;
  logic [31:0] next_hrdata;
  logic        wr_pend;
  logic        next_wr_pend;
  logic [7:0]  wr_addr;
  logic [7:0]  next_wr_addr;
  logic        rd_req;
  logic        wr_req;
  cfs_clr_t    clr_state;
  cfs_clr_t    next_clr_state;
  logic        load_err;
  logic        next_load_err;
  logic        param_err;
  logic        cmp_a;
  logic        cmp_b;
  logic        next_cmp_a;
  logic        next_cmp_b;
  logic        out_a_q;
  logic        out_b_q;
  logic [4:0]  next_load_cmd;
  logic        next_irq;
  logic        next_reject;
  logic        conflict;
  logic        load_any;
  logic        clr_pulse;
  logic        trans;
  logic [CFS_NUM_FAULT-1:0] fault_flag;
  logic [CFS_NUM_FAULT-1:0] fault_vec;
  logic [31:0] status;
  logic [CFS_NUM_IRQ-1:0]   irq_ev;

  assign fault_vec = fault_in;
  assign trans = ctrl[CFS_CTL_ACK] || ctrl[CFS_CTL_STOP];

  genvar gi;
  generate
    for (gi = 0; gi < CFS_NUM_FAULT; gi++) begin : g_fault
      cfs_fault_latch u_latch (
        .clk         (clk),
        .srst        (srst),
        .cause       (fault_vec[CFS_NUM_FAULT-1-gi]),
        .ack         (ctrl[CFS_CTL_ACK]),
        .transparent (trans),
        .flag        (fault_flag[gi])
      );
    end
  endgenerate

  // load command checks
  always_comb begin
    load_any = |ctrl[CFS_CTL_LOAD0 +: 5];
    conflict = ($countones(ctrl[CFS_CTL_LOAD0 +: 5]) > 1);
    next_load_cmd = conflict ? 5'h00 : ctrl[CFS_CTL_LOAD0 +: 5];
    next_reject = load_any && !conflict && core_in.load_value_bad;
    if (conflict || next_reject) begin
      next_load_err = 1'b1;
    end else if (!load_any) begin
      next_load_err = load_err;
    end else begin
      next_load_err = 1'b0; // correct load clears it
    end
  end

  // status clear handshake
  always_comb begin
    next_clr_state = clr_state;
    case (clr_state)
      CFS_CLR_IDLE: begin
        if (ctrl[CFS_CTL_CLR_REQ]) begin
          next_clr_state = CFS_CLR_ACTIVE;
        end
      end
      CFS_CLR_ACTIVE: begin
        if (!ctrl[CFS_CTL_CLR_REQ]) begin
          next_clr_state = CFS_CLR_IDLE;
        end
      end
      default: next_clr_state = CFS_CLR_IDLE;
    endcase
  end
  assign clr_pulse = (clr_state == CFS_CLR_IDLE) && ctrl[CFS_CTL_CLR_REQ];

  // comparator flags, set wins over clear
  always_comb begin
    next_cmp_a = cmp_a;
    next_cmp_b = cmp_b;
    if (clr_pulse) begin
      next_cmp_a = 1'b0;
      next_cmp_b = 1'b0;
    end
    if (core_in.output_a) begin
      next_cmp_a = 1'b1;
    end
    if (core_in.output_b) begin
      next_cmp_b = 1'b1;
    end
    if (ctrl[CFS_CTL_SW_A] && !ctrl[CFS_CTL_EN_A]) begin
      next_cmp_a = 1'b1;
    end
    if (ctrl[CFS_CTL_SW_B] && !ctrl[CFS_CTL_EN_B]) begin
      next_cmp_b = 1'b1;
    end
  end

  always_comb begin
    status = 32'h0000_0000;
    status[CFS_ST_SUPPLY]  = fault_flag[0];
    status[CFS_ST_OUT_A]   = fault_flag[1];
    status[CFS_ST_OUT_B]   = fault_flag[2];
    status[CFS_ST_ENC]     = fault_flag[3];
    status[CFS_ST_LOAD]    = load_err;
    status[CFS_ST_PARAM]   = param_err;
    status[CFS_ST_CLR_ACT] = (clr_state == CFS_CLR_ACTIVE);
    status[CFS_ST_CMP_A]   = cmp_a;
    status[CFS_ST_CMP_B]   = cmp_b;
    status[CFS_ST_IN]      = core_in.switch_input_pin;
    status[CFS_ST_OA]      = core_in.output_a;
    status[CFS_ST_OB]      = core_in.output_b;
    status[CFS_ST_UP]      = core_in.dir_up;
    status[CFS_ST_DN]      = core_in.dir_down;
  end

  // interrupt events: rising edges of error and comparator flags
  assign irq_ev = {next_cmp_b & ~cmp_b, next_cmp_a & ~cmp_a,
                   core_in.param_bad & ~param_err,
                   next_load_err & ~load_err,
                   fault_vec & ~{fault_flag[0], fault_flag[1],
                                 fault_flag[2], fault_flag[3]}};

  // bus slave
  always_comb begin
    rd_req = hsel && hready && htrans[1] && !hwrite;
    wr_req = hsel && hready && htrans[1] && hwrite;
    next_wr_pend = wr_req;
    next_wr_addr = wr_req ? haddr : wr_addr;
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    next_irq_st = irq_st;
    if (wr_pend) begin
      if (wr_addr == CFS_OFS_CTRL) begin
        next_ctrl = hwdata & CFS_CTRL_WMASK;
      end else if (wr_addr == CFS_OFS_IRQ_ST) begin
        next_irq_st = irq_st & ~hwdata;
      end else if (wr_addr == CFS_OFS_IRQ_MK) begin
        next_irq_mask = hwdata & {{(32-CFS_NUM_IRQ){1'b0}}, {CFS_NUM_IRQ{1'b1}}};
      end
    end
    next_irq_st[CFS_NUM_IRQ-1:0] = next_irq_st[CFS_NUM_IRQ-1:0] | irq_ev;
    next_hrdata = hrdata;
    if (rd_req) begin
      if (haddr == CFS_OFS_CTRL) begin
        next_hrdata = ctrl;
      end else if (haddr == CFS_OFS_STATUS) begin
        next_hrdata = status;
      end else if (haddr == CFS_OFS_IRQ_ST) begin
        next_hrdata = irq_st;
      end else if (haddr == CFS_OFS_IRQ_MK) begin
        next_hrdata = irq_mask;
      end else begin
        next_hrdata = 32'h0000_0000;
      end
    end
    next_irq = |(next_irq_st & next_irq_mask);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl        <= CFS_CTRL_RST;
      irq_mask    <= CFS_MASK_RST;
      irq_st      <= 32'h0000_0000;
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      clr_state   <= CFS_CLR_IDLE;
      load_err    <= 1'b0;
      param_err   <= 1'b0;
      cmp_a       <= 1'b0;
      cmp_b       <= 1'b0;
      out_a_q     <= 1'b0;
      out_b_q     <= 1'b0;
      load_cmd    <= 5'h00;
      load_reject <= 1'b0;
      irq         <= 1'b0;
    end else begin
      ctrl        <= next_ctrl;
      irq_mask    <= next_irq_mask;
      irq_st      <= next_irq_st;
      wr_pend     <= next_wr_pend;
      wr_addr     <= next_wr_addr;
      hrdata      <= next_hrdata;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      clr_state   <= next_clr_state;
      load_err    <= next_load_err;
      param_err   <= core_in.param_bad;
      cmp_a       <= next_cmp_a;
      cmp_b       <= next_cmp_b;
      out_a_q     <= core_in.output_a;
      out_b_q     <= core_in.output_b;
      load_cmd    <= next_load_cmd;
      load_reject <= next_reject;
      irq         <= next_irq;
    end
  end
endmodule
`default_nettype wire

// [cfs_pkg.sv]
// Purpose: shared constants and types for the counter feedback status block
// Assumes: 32-bit AHB-Lite register access, word aligned
// Notes:   offsets are byte addresses
package cfs_pkg;
  localparam logic [7:0] CFS_OFS_CTRL   = 8'h00;
  localparam logic [7:0] CFS_OFS_STATUS = 8'h04;
  localparam logic [7:0] CFS_OFS_IRQ_ST = 8'h08;
  localparam logic [7:0] CFS_OFS_IRQ_MK = 8'h0C;
  // control register fields
  localparam int CFS_CTL_ACK     = 0;
  localparam int CFS_CTL_CLR_REQ = 1;
  localparam int CFS_CTL_SW_A    = 2;
  localparam int CFS_CTL_SW_B    = 3;
  localparam int CFS_CTL_EN_A    = 4;
  localparam int CFS_CTL_EN_B    = 5;
  localparam int CFS_CTL_LOAD0   = 8;
  localparam int CFS_CTL_STOP    = 13;
  localparam logic [31:0] CFS_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] CFS_MASK_RST   = 32'h0000_0000;
  localparam logic [31:0] CFS_CTRL_WMASK = 32'h0000_3F3F;
  // status word fields
  localparam int CFS_ST_SUPPLY  = 0;
  localparam int CFS_ST_OUT_A   = 1;
  localparam int CFS_ST_OUT_B   = 2;
  localparam int CFS_ST_ENC     = 3;
  localparam int CFS_ST_LOAD    = 4;
  localparam int CFS_ST_PARAM   = 5;
  localparam int CFS_ST_CLR_ACT = 6;
  localparam int CFS_ST_CMP_A   = 7;
  localparam int CFS_ST_CMP_B   = 8;
  localparam int CFS_ST_IN      = 9;
  localparam int CFS_ST_OA      = 10;
  localparam int CFS_ST_OB      = 11;
  localparam int CFS_ST_UP      = 12;
  localparam int CFS_ST_DN      = 13;
  localparam int CFS_NUM_FAULT  = 4;
  // one event bit per fault, load, parameter and each comparator
  localparam int CFS_NUM_IRQ    = 8;

  typedef struct packed {
    logic supply_short;
    logic out_a_fault;
    logic out_b_fault;
    logic enc_fault;
  } cfs_fault_t;

  typedef struct packed {
    logic output_a;
    logic output_b;
    logic switch_input_pin;
    logic dir_up;
    logic dir_down;
    logic load_value_bad;
    logic param_bad;
  } cfs_core_t;

  typedef enum logic [1:0] {CFS_CLR_IDLE, CFS_CLR_ACTIVE} cfs_clr_t;
endpackage

// [cfs_fault_latch.sv]
// Purpose: one latched fault flag with acknowledge
// Assumes: synchronous inputs
// Notes:   transparent while acknowledge held or controller stopped
`timescale 1ns/100ps
`default_nettype none
module cfs_fault_latch (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // control
  input  wire logic cause,
  input  wire logic ack,
  input  wire logic transparent,
  // flag
  output var  logic flag
);
  logic next_flag;
  logic ack_q;

  always_comb begin
    if (transparent) begin
      next_flag = cause;
    end else if (cause) begin
      next_flag = 1'b1; // set beats acknowledge
    end else if (ack && !ack_q) begin
      next_flag = 1'b0;
    end else begin
      next_flag = flag;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flag  <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      flag  <= next_flag;
      ack_q <= ack;
    end
  end
endmodule
`default_nettype wire

// [cfs_top_sva.sv]
// Purpose: port-level checks of the feedback status block
// Assumes: zero wait state slave, one clock
// Notes:   attached to cfs_top by bind
`timescale 1ns/100ps
`default_nettype none
module cfs_top_chk
  import cfs_pkg::*;
(
  // clock and reset
  input wire logic               clk,
  input wire logic               srst,
  // bus
  input wire logic               hsel,
  input wire logic [7:0]         haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  // core side
  input wire cfs_pkg::cfs_core_t core_in,
  input wire logic [4:0]         load_cmd,
  input wire logic               load_reject
);
  logic rd_st;
  logic rd_un;
  logic next_rd_st;
  logic next_rd_un;
  always_comb begin
    next_rd_st = hsel && hready && htrans[1] && !hwrite;
    next_rd_un = next_rd_st && haddr > CFS_OFS_IRQ_MK;
    next_rd_st = next_rd_st && haddr == CFS_OFS_STATUS;
  end
  always_ff @(posedge clk) begin
    rd_st <= srst ? 1'h0 : next_rd_st;
    rd_un <= srst ? 1'h0 : next_rd_un;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ok_resp_a: assert property (hresp == 1'h0)
    else $error("bus answer not okay");
  ready_high_a: assert property (hreadyout == 1'h1)
    else $error("wait state inserted");
  load_single_a: assert property ($onehot0(load_cmd))
    else $error("several load commands passed on");
  reject_cause_a: assert property (
    load_reject |-> $past(core_in.load_value_bad))
    else $error("load refused without bad value");
  in_live_a: assert property (rd_st |->
    hrdata[CFS_ST_IN] == $past(core_in.switch_input_pin))
    else $error("input level not mirrored");
  out_live_a: assert property (rd_st |->
    hrdata[11:10] == $past({core_in.output_b, core_in.output_a}))
    else $error("output state not mirrored");
  dir_live_a: assert property (rd_st |->
    hrdata[13:12] == $past({core_in.dir_down, core_in.dir_up}))
    else $error("direction not mirrored");
  unmapped_zero_a: assert property (rd_un |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind cfs_top cfs_top_chk cfs_top_chk_inst (.clk(clk), .srst(srst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .core_in(core_in), .load_cmd(load_cmd), .load_reject(load_reject));
`default_nettype wire

// [cfs_bus_master.sv]
// Purpose: fieldbus controller side issuing single word transfers
// Assumes: called just after a rising edge
// Notes:   waits are bounded, overrun reported to caller
`timescale 1ns/100ps
`default_nettype none
module cfs_bus_master (
  // clock
  input  wire logic        clk,
  // ahb-lite master
  output var  logic        hsel = 1'h0,
  output var  logic [7:0]  haddr = 8'h00,
  output var  logic [1:0]  htrans = 2'h0,
  output var  logic        hwrite = 1'h0,
  output var  logic [2:0]  hsize = 3'h2,
  output var  logic [31:0] hwdata = 32'h0,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic to);
    int n;
    n = 0;
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'h1 && ++n < 40);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1 && ++n < 40);
    q = hrdata;
    to = n >= 40;
  endtask
endmodule
`default_nettype wire

// [test_counter_feedback_status.sv]
// Purpose: register-level test of the feedback status block
// Assumes: zero wait state bus, flags settle within two cycles
// Notes:   field causes driven directly by the bench
`timescale 1ns/100ps
`default_nettype none
module test_counter_feedback_status;
  import cfs_pkg::*;
  logic        clk = 1'h0;
  logic        srst = 1'h1;
  logic        hsel, hwrite, hreadyout, hresp, irq, load_reject;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, r;
  logic [4:0]  load_cmd;
  cfs_fault_t  f = 4'h0;
  cfs_core_t   c = 7'h00;
  int          miscompares = 0;
  int          checks_done = 0;
  cfs_bus_master cfs_bus_master_inst (.clk(clk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));
  cfs_top cfs_top_inst (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fault_in(f), .core_in(c), .load_cmd(load_cmd),
    .load_reject(load_reject), .irq(irq));
  initial forever #10 clk = ~clk;
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic to;
    cfs_bus_master_inst.xfer(1'h1, a, d, r, to);
    if (to) begin
      miscompares++;
      close_out();
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string nm);
    logic to;
    cfs_bus_master_inst.xfer(1'h0, a, 32'h0, r, to);
    if (to) miscompares++;
    if (to) close_out();
    chk(nm, e, r & m);
  endtask
  task settle;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    rd(CFS_OFS_CTRL, 32'hFFFFFFFF, CFS_CTRL_RST, "ctrl reset");
    rd(CFS_OFS_IRQ_MK, 32'hFFFFFFFF, CFS_MASK_RST, "mask reset");
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'hFFFFFFFF, 32'h0, "unmapped");
    c <= 7'h7C;
    settle();
    rd(CFS_OFS_STATUS, 32'h3E00, 32'h3E00, "live bits");
    c <= 7'h00;
    wr(CFS_OFS_IRQ_ST, 32'hFF);
    wr(CFS_OFS_IRQ_MK, 32'hFF);
    rd(CFS_OFS_IRQ_MK, 32'hFFFFFFFF, 32'hFF, "mask");
    for (int i = 0; i < 4; i++) begin
      f <= 4'h8 >> i;
      settle();
      f <= 4'h0;
      settle();
      rd(CFS_OFS_STATUS, 32'h1 << i, 32'h1 << i, "fault held");
      rd(CFS_OFS_IRQ_ST, 32'h8 >> i, 32'h8 >> i, "fault event");
      wr(CFS_OFS_CTRL, 32'h1);
      wr(CFS_OFS_CTRL, 32'h0);
      rd(CFS_OFS_STATUS, 32'h1 << i, 32'h0, "fault acked");
    end
    for (int k = 0; k < 2; k++) begin
      wr(CFS_OFS_CTRL, k ? 32'h2000 : 32'h1);
      f <= 4'h1;
      settle();
      rd(CFS_OFS_STATUS, 32'h8, 32'h8, "follow set");
      f <= 4'h0;
      settle();
      rd(CFS_OFS_STATUS, 32'h8, 32'h0, "follow clear");
      wr(CFS_OFS_CTRL, 32'h0);
    end
    wr(CFS_OFS_CTRL, 32'h300);
    settle();
    chk("load_cmd", 32'h0, {27'h0, load_cmd});
    rd(CFS_OFS_STATUS, 32'h10, 32'h10, "load conflict");
    wr(CFS_OFS_CTRL, 32'h0);
    rd(CFS_OFS_STATUS, 32'h10, 32'h10, "load held");
    wr(CFS_OFS_CTRL, 32'h400);
    // load error register updates one edge after the control word lands
    settle();
    rd(CFS_OFS_STATUS, 32'h10, 32'h0, "load cleared");
    for (int k = 0; k < 5; k++) begin
      wr(CFS_OFS_CTRL, 32'h100 << k);
      settle();
      chk("load_cmd", 32'h1 << k, {27'h0, load_cmd});
    end
    c <= 7'h03;
    wr(CFS_OFS_CTRL, 32'h100);
    settle();
    chk("load_reject", 32'h1, {31'h0, load_reject});
    rd(CFS_OFS_STATUS, 32'h30, 32'h30, "bad value");
    c <= 7'h40;
    wr(CFS_OFS_CTRL, 32'h0);
    c <= 7'h00;
    rd(CFS_OFS_STATUS, 32'h80, 32'h80, "cmp held");
    wr(CFS_OFS_CTRL, 32'h2);
    // handshake state and flags move one edge after the request lands
    settle();
    rd(CFS_OFS_STATUS, 32'h1C0, 32'h40, "clear active");
    wr(CFS_OFS_CTRL, 32'h0);
    settle();
    rd(CFS_OFS_STATUS, 32'h40, 32'h0, "clear done");
    c <= 7'h40;
    wr(CFS_OFS_CTRL, 32'h2);
    settle();
    rd(CFS_OFS_STATUS, 32'h80, 32'h80, "cmp sets again");
    c <= 7'h00;
    wr(CFS_OFS_CTRL, 32'h8);
    settle();
    rd(CFS_OFS_STATUS, 32'h100, 32'h100, "manual switch");
    wr(CFS_OFS_CTRL, 32'h0);
    wr(CFS_OFS_IRQ_MK, 32'h0);
    settle();
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(CFS_OFS_IRQ_MK, 32'hFF);
    settle();
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(CFS_OFS_IRQ_ST, 32'hFF);
    settle();
    chk("irq cleared", 32'h0, {31'h0, irq});
    close_out();
  end
endmodule
`default_nettype wire
